// ---- src/isf_cond.sv ----
/*
  Start and stop detector with frame bit counter.
  Assumes synchronised line levels from the carrier.
*/
`timescale 1ns/100ps
module isf_cond
  import isf_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  isf_link_if.det   lnk
);

  typedef struct packed {
    logic             scl_d;
    logic             sda_d;
    isf_bus_t         bus;
    logic [CNT_W-1:0] cnt;
    logic             open;
    logic             start_p;
    logic             stop_err_p;
    logic             stop_ok_p;
  } isf_cond_st_t;

  isf_cond_st_t st_ff;
  isf_cond_st_t nxt_st;
  logic         scl_rise;
  logic         sda_rise;
  logic         sda_fall;

  always_comb begin
    scl_rise = lnk.scl_s & ~st_ff.scl_d;
    sda_rise = lnk.sda_s & ~st_ff.sda_d;
    sda_fall = ~lnk.sda_s & st_ff.sda_d;
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.scl_d      = lnk.scl_s;
      nxt_st.sda_d      = lnk.sda_s;
      nxt_st.start_p    = 1'b0;
      nxt_st.stop_err_p = 1'b0;
      nxt_st.stop_ok_p  = 1'b0;
      // A stop needs its own clock rise, so judge by the count before it
      if (scl_rise) begin
        nxt_st.open = (st_ff.cnt != CNT_ZERO);
        nxt_st.cnt  = (st_ff.cnt == BITS_FRAME - CNT_ONE) ? CNT_ZERO : st_ff.cnt + CNT_ONE;
      end
      if (lnk.scl_s && st_ff.scl_d && sda_fall) begin
        nxt_st.bus     = ISF_BUSY;
        nxt_st.cnt     = CNT_ZERO;
        nxt_st.open    = 1'b0;
        nxt_st.start_p = 1'b1;
      end else if (lnk.scl_s && st_ff.scl_d && sda_rise) begin
        nxt_st.bus = ISF_IDLE;
        nxt_st.cnt = CNT_ZERO;
        case (st_ff.bus)
          ISF_BUSY: begin
            nxt_st.stop_err_p = st_ff.open;
            nxt_st.stop_ok_p  = ~st_ff.open;
          end
          default: begin
            nxt_st.stop_ok_p = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '{scl_d: 1'b1, sda_d: 1'b1, bus: ISF_IDLE, cnt: CNT_ZERO, default: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.start_p    = st_ff.start_p;
  assign lnk.stop_err_p = st_ff.stop_err_p;
  assign lnk.stop_ok_p  = st_ff.stop_ok_p;
  assign lnk.busy       = (st_ff.bus == ISF_BUSY);

endmodule : isf_cond

// ---- src/isf_link_if.sv ----
/*
  Carrier between the bus condition detector and the flag core.
  Assumes the line levels are already synchronised to clk_sys.
*/
`timescale 1ns/100ps
interface isf_link_if;
  logic scl_s;
  logic sda_s;
  logic start_p;
  logic stop_err_p;
  logic stop_ok_p;
  logic busy;

  modport det (
    input  scl_s,
    input  sda_s,
    output start_p,
    output stop_err_p,
    output stop_ok_p,
    output busy
  );

  modport core (
    output scl_s,
    output sda_s,
    input  start_p,
    input  stop_err_p,
    input  stop_ok_p,
    input  busy
  );
endinterface : isf_link_if

// ---- src/isf_pkg.sv ----
/*
  Constants and types of the two-wire bus status flag block.
  Assumes a single system clock and a byte-wide register port.
*/
package isf_pkg;

  // ********************************
  // Register port
  // ********************************
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] REG_STATUS   = 3'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL     = 3'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 3'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 3'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 3'h4;

  // ********************************
  // Field positions
  // ********************************
  localparam int unsigned ST_FERR  = 7;
  localparam int unsigned ST_STOP  = 6;
  localparam int unsigned ST_CXFR  = 5;
  localparam int unsigned CT_MAIN  = 0;
  localparam int unsigned CT_STOPM = 1;
  localparam int unsigned CT_SLAVE = 2;
  localparam int unsigned CT_BUSY  = 3;
  localparam int unsigned IRQ_W    = 3;
  localparam int unsigned IQ_FERR  = 0;
  localparam int unsigned IQ_STOP  = 1;
  localparam int unsigned IQ_CXFR  = 2;

  // ********************************
  // Reset values and counts
  // ********************************
  localparam logic             RST_FLAG   = 1'b0;
  localparam logic [DATA_W-1:0] RST_BYTE  = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ    = 3'h0;
  localparam int unsigned      CNT_W      = 4;
  localparam logic [CNT_W-1:0] BITS_FRAME = 4'h9;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;

  typedef enum logic {ISF_IDLE, ISF_BUSY} isf_bus_t;

endpackage : isf_pkg

// ---- src/isf_sync.sv ----
/*
  Two-stage synchroniser for levels from outside the clk_sys domain.
  Assumes inputs are slow compared with clk_sys.
*/
`timescale 1ns/100ps
module isf_sync
  import isf_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } isf_sync_st_t;

  isf_sync_st_t st_ff;
  isf_sync_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Lines idle high, so no false edge follows reset
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;

endmodule : isf_sync

// ---- src/isf_top.sv ----
/*
  Upper status flags of the two-wire bus status register, the main
  interrupt request flag and a small event interrupt unit.
  Assumes scl_i and sda_i come from pins, all other inputs from clk_sys logic.
*/
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps

//  Function
//  - Status register is eight bits, read and written by the CPU.
//  - Slave mode stop during a frame sets the frame stop error flag, bit 7.
//  - Slave mode stop after a frame sets the normal stop flag, bit 6.
//  - Both stop flags mean something only in two-wire slave mode.
//  - Frame stop error flag clears by writing 0 after reading 1.
//  - Normal stop flag clears by writing 0 after reading 1.
//  - Clearing the main interrupt flag also clears both stop flags.
//  - Setting the continuous transfer flag sets the main interrupt flag too.
//  - Continuous transfer flag sets only when transmit empty or receive full rises.
//  - Continuous transfer flag clears by writing 0 after reading 1.
//  - Continuous transfer flag clears whenever the main interrupt flag clears.
//  - Zero means waiting or transferring; the three upper flags reset to zero.
//  - In slave mode it needs the second address match; otherwise always.
//  - After a primary or general call match, it waits for stop or start; here only primary_address_match arms the wait.
module isf_top
  import isf_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  input  wire logic              transmit_data_empty_flag,
  input  wire logic              receive_data_full_flag,
  input  wire logic              second_address_match_flag,
  input  wire logic              primary_address_match,
  output logic                   main_irq,
  output logic                   irq
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic              ferr;
    logic              stop;
    logic              cxfr;
    logic              mflag;
    logic              stop_mask;
    logic              slave;
    logic [3:0]        arm;
    logic              txe_d;
    logic              rxf_d;
    logic              hold;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_en;
    logic [DATA_W-1:0] rdata;
    logic              irq;
  } isf_st_t;

  localparam int unsigned A_FERR = 0;
  localparam int unsigned A_STOP = 1;
  localparam int unsigned A_CXFR = 2;
  localparam int unsigned A_MAIN = 3;

  isf_st_t           st_ff;
  isf_st_t           nxt_st;
  isf_link_if        lnk ();
  logic [DATA_W-1:0] status_rd;
  logic [DATA_W-1:0] ctrl_rd;
  logic              wr_st;
  logic              wr_ct;
  logic              set_ferr;
  logic              set_stop;
  logic              set_cxfr;
  logic              set_main;
  logic              clr_main;
  logic              xfer_rise;
  logic [IRQ_W-1:0]  ev;

  // ********************************
  // Line synchronisers and detector
  // ********************************
  isf_sync #(.W(1)) u_sync_scl (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .d       (scl_i),
    .q       (lnk.scl_s)
  );

  isf_sync #(.W(1)) u_sync_sda (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .d       (sda_i),
    .q       (lnk.sda_s)
  );

  isf_cond u_cond (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .lnk     (lnk.det)
  );

  // ********************************
  // Flag logic
  // ********************************
  always_comb begin
    status_rd = RST_BYTE;
    status_rd[ST_FERR] = st_ff.ferr;
    status_rd[ST_STOP] = st_ff.stop;
    status_rd[ST_CXFR] = st_ff.cxfr;
    ctrl_rd = RST_BYTE;
    ctrl_rd[CT_MAIN]  = st_ff.mflag;
    ctrl_rd[CT_STOPM] = st_ff.stop_mask;
    ctrl_rd[CT_SLAVE] = st_ff.slave;
    ctrl_rd[CT_BUSY]  = lnk.busy;

    wr_st = wr && (addr == REG_STATUS);
    wr_ct = wr && (addr == REG_CTRL);

    // Stop flags only ever set in slave mode
    set_ferr = st_ff.slave & lnk.stop_err_p;
    set_stop = st_ff.slave & lnk.stop_ok_p;

    xfer_rise = (transmit_data_empty_flag & ~st_ff.txe_d)
              | (receive_data_full_flag & ~st_ff.rxf_d);
    set_cxfr = xfer_rise & ~st_ff.hold
             & (~st_ff.slave | second_address_match_flag);

    set_main = set_cxfr | ((set_ferr | set_stop) & ~st_ff.stop_mask);
    // An event in the clearing cycle wins over the clear
    clr_main = wr_ct & st_ff.arm[A_MAIN] & ~wdata[CT_MAIN] & ~set_main;

    ev = RST_IRQ;
    ev[IQ_FERR] = set_ferr;
    ev[IQ_STOP] = set_stop;
    ev[IQ_CXFR] = set_cxfr;

    nxt_st = st_ff;
    if (ce) begin
      nxt_st.txe_d = transmit_data_empty_flag;
      nxt_st.rxf_d = receive_data_full_flag;
      nxt_st.rdata  = RST_BYTE;

      if (st_ff.slave && primary_address_match) begin
        nxt_st.hold = 1'b1;
      end
      if (lnk.stop_err_p || lnk.stop_ok_p || lnk.start_p || !st_ff.slave) begin
        nxt_st.hold = 1'b0;
      end

      // Read side: return data and arm flags seen as 1
      if (rd) begin
        case (addr)
          REG_STATUS: begin
            nxt_st.rdata = status_rd;
            nxt_st.arm[A_FERR] = st_ff.ferr;
            nxt_st.arm[A_STOP] = st_ff.stop;
            nxt_st.arm[A_CXFR] = st_ff.cxfr;
          end
          REG_CTRL: begin
            nxt_st.rdata = ctrl_rd;
            nxt_st.arm[A_MAIN] = st_ff.mflag;
          end
          REG_IRQ_STAT: begin
            nxt_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_ff.irq_stat};
          end
          REG_IRQ_EN: begin
            nxt_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_ff.irq_en};
          end
          default: begin
            nxt_st.rdata = RST_BYTE;
          end
        endcase
      end

      // Status writes: a 0 clears only an armed flag, a 1 is ignored
      if (wr_st) begin
        if (st_ff.arm[A_FERR] && !wdata[ST_FERR]) begin
          nxt_st.ferr = 1'b0;
        end
        if (st_ff.arm[A_STOP] && !wdata[ST_STOP]) begin
          nxt_st.stop = 1'b0;
        end
        if (st_ff.arm[A_CXFR] && !wdata[ST_CXFR]) begin
          nxt_st.cxfr = 1'b0;
        end
        nxt_st.arm[A_FERR] = 1'b0;
        nxt_st.arm[A_STOP] = 1'b0;
        nxt_st.arm[A_CXFR] = 1'b0;
      end

      if (wr_ct) begin
        nxt_st.stop_mask = wdata[CT_STOPM];
        nxt_st.slave     = wdata[CT_SLAVE];
        nxt_st.arm[A_MAIN] = 1'b0;
      end

      if (clr_main) begin
        nxt_st.mflag = 1'b0;
        nxt_st.ferr = 1'b0;
        nxt_st.stop = 1'b0;
        nxt_st.cxfr = 1'b0;
      end

      // Hardware sets last so they beat any clear
      if (set_ferr) begin
        nxt_st.ferr = 1'b1;
      end
      if (set_stop) begin
        nxt_st.stop = 1'b1;
      end
      if (set_cxfr) begin
        nxt_st.cxfr = 1'b1;
      end
      if (set_main) begin
        nxt_st.mflag = 1'b1;
      end

      // ********************************
      // Event interrupt unit
      // ********************************
      if (wr && (addr == REG_IRQ_EN)) begin
        nxt_st.irq_en = wdata[IRQ_W-1:0];
      end
      if (wr && (addr == REG_IRQ_CLR)) begin
        nxt_st.irq_stat = st_ff.irq_stat & ~wdata[IRQ_W-1:0];
      end
      nxt_st.irq_stat = nxt_st.irq_stat | ev;
      nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '{irq_stat: RST_IRQ, irq_en: RST_IRQ, rdata: RST_BYTE, arm: 4'h0, default: RST_FLAG};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata    = st_ff.rdata;
  assign main_irq = st_ff.mflag;
  assign irq      = st_ff.irq;

endmodule : isf_top

// ---- verif/isf_bus_model.sv ----
/*
  Two-wire bus master model: start, data clocks and stop on the lines.
  Assumes pull-ups, so both lines idle high and the clock stands still
  between frames.
*/
`timescale 1ns/100ps
module isf_bus_model (
  output logic scl,
  output logic sda
);
  localparam time HALF = 400ns;

  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Step off the sampling edge of clk_sys before the first change
  task automatic start();
    #(HALF/8) sda = 1'b0;
    #HALF scl = 1'b0;
  endtask : start

  // Data moves a quarter period after the clock falls, never with it
  task automatic bits(input int n);
    for (int i = 0; i < n; i++) begin
      #(HALF/2) sda = i[0];
      #(HALF/2) scl = 1'b1;
      #HALF scl = 1'b0;
    end
  endtask : bits

  task automatic stop();
    #(HALF/2) sda = 1'b0;
    #(HALF/2) scl = 1'b1;
    #HALF sda = 1'b1;
    #HALF;
  endtask : stop
endmodule : isf_bus_model

// ---- verif/isf_top_chk.sv ----
/*
  Port checker of isf_top.
  Assumes it is bound to every isf_top instance.
*/
`timescale 1ns/100ps
module isf_top_chk
  import isf_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic              transmit_data_empty_flag,
  input wire logic              receive_data_full_flag,
  input wire logic              second_address_match_flag,
  input wire logic              primary_address_match,
  input wire logic              main_irq,
  input wire logic              irq
);
  logic sl_ff;
  logic am_ff;
  logic wc;
  logic up;

  assign wc = ce && wr && addr == REG_CTRL;
  assign up = transmit_data_empty_flag || receive_data_full_flag;

  // Mirror of slave mode and of the main flag's read-one arming
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sl_ff <= 1'b0;
      am_ff <= 1'b0;
    end else begin
      if (wc) sl_ff <= wdata[CT_SLAVE];
      if (wc) am_ff <= 1'b0;
      else if (ce && rd && addr == REG_CTRL && main_irq) am_ff <= 1'b1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_rd_idle; ce && !rd |=> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rst_zero; $fell(rst) |-> rdata == 8'h00 && !main_irq && !irq; endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("outputs not clear after reset");
  property p_cxfr_main; ce && rd && addr == REG_STATUS |=> !rdata[ST_CXFR] || $past(main_irq); endproperty
  a_cxfr_main: assert property (p_cxfr_main) else $error("transfer flag without main flag");
  property p_set_open;
    ce && !sl_ff && ($rose(transmit_data_empty_flag) || $rose(receive_data_full_flag)) |=> main_irq;
  endproperty
  a_set_open: assert property (p_set_open) else $error("transfer event lost");
  property p_slave_gate;
    ce && sl_ff && !second_address_match_flag && !main_irq
      && ($rose(transmit_data_empty_flag) || $rose(receive_data_full_flag)) |=> !main_irq;
  endproperty
  a_slave_gate: assert property (p_slave_gate) else $error("slave set without second match");
  property p_main_clr; wc && !wdata[CT_MAIN] && am_ff && !up |=> !main_irq; endproperty
  a_main_clr: assert property (p_main_clr) else $error("main flag not cleared");
  property p_w1_keep; wc && wdata[CT_MAIN] && main_irq |=> main_irq; endproperty
  a_w1_keep: assert property (p_w1_keep) else $error("write of one changed main flag");
  property p_no_arm; wc && !wdata[CT_MAIN] && !am_ff && main_irq |=> main_irq; endproperty
  a_no_arm: assert property (p_no_arm) else $error("cleared without prior read");
endmodule : isf_top_chk

bind isf_top isf_top_chk i_chk (
  .clk_sys, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .scl_i, .sda_i,
  .transmit_data_empty_flag, .receive_data_full_flag, .second_address_match_flag,
  .primary_address_match, .main_irq, .irq
);

// ---- verif/isf_top_tb.sv ----
/*
  Self-checking bench of isf_top against an integer flag model.
  Assumes the package, carrier, design, checker and bus model compiled first.
*/
`timescale 1ns/100ps
module isf_top_tb
  import isf_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] addr = 3'h0;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, tx_empty = 1'b0, rx_full = 1'b0, match2 = 1'b0, match1 = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic scl, sda, main_irq, irq;
  logic [31:0] rs = 32'he5cd;
  int bad_count = 0, n_checks = 0, cyc = 0;
  int st = 0, mn = 0, sl = 0, mk = 0, hold = 0, ist = 0, ien = 0, ast = 0, amn = 0;

  always #50 clk_sys = ~clk_sys;

  isf_top i_dut (
    .clk_sys, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .scl_i(scl), .sda_i(sda),
    .transmit_data_empty_flag(tx_empty), .receive_data_full_flag(rx_full),
    .second_address_match_flag(match2), .primary_address_match(match1), .main_irq, .irq
  );
  isf_bus_model i_bus (.scl, .sda);

  // **********
  // Tasks
  // **********
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lf

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    case (a)
      REG_STATUS: begin
        st &= ~(ast & ~v);
        ast = 0;
      end
      REG_CTRL: begin
        if (amn && !v[0]) begin
          mn = 0;
          st = 0;
        end
        amn = 0;
        mk = v[1];
        sl = v[2];
        if (!sl) hold = 0;
      end
      REG_IRQ_CLR: ist &= ~v;
      REG_IRQ_EN: ien = v & 7;
      default: ;
    endcase
  endtask : wreg

  task automatic rreg(input logic [2:0] a);
    int e;
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    e = a == REG_STATUS ? st : a == REG_CTRL ? mn | mk << 1 | sl << 2 :
        a == REG_IRQ_STAT ? ist : a == REG_IRQ_EN ? ien : 0;
    chk("rdata", rdata, e[7:0]);
    if (a == REG_STATUS) ast |= st;
    if (a == REG_CTRL) amn |= mn;
  endtask : rreg

  task automatic pins();
    repeat (2) @(negedge clk_sys);
    chk("main_irq", {7'h0, main_irq}, mn[7:0]);
    chk("irq", {7'h0, irq}, {7'h0, |(ist & ien)});
  endtask : pins

  task automatic xfer(input bit full);
    @(posedge clk_sys);
    if (full) rx_full <= 1'b1;
    else tx_empty <= 1'b1;
    if (!sl || (match2 && !hold)) begin
      st |= 8'h20;
      mn = 1;
      ist |= 4;
    end
    @(posedge clk_sys);
    tx_empty <= 1'b0;
    rx_full <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : xfer

  task automatic frame(input int n);
    i_bus.start();
    hold = 0;
    i_bus.bits(n);
    i_bus.stop();
    if (sl) begin
      st |= n % 9 ? 8'h80 : 8'h40;
      ist |= n % 9 ? 1 : 2;
      if (!mk) mn = 1;
    end
    repeat (6) @(posedge clk_sys);
  endtask : frame

  // Hang guard well above the several hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  // **********
  // Sequence
  // **********
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) if (a != 3) rreg(a[2:0]);
    pins();
    xfer(0);
    wreg(REG_STATUS, 8'h00);
    wreg(REG_STATUS, 8'he0);
    rreg(REG_STATUS);
    wreg(REG_STATUS, 8'h00);
    rreg(REG_STATUS);
    xfer(1);
    wreg(REG_CTRL, 8'h00);
    wreg(REG_CTRL, 8'h01);
    rreg(REG_CTRL);
    wreg(REG_CTRL, 8'h00);
    rreg(REG_STATUS);
    pins();
    // Frozen clock enable: a rise seen only while ce is low is lost
    @(posedge clk_sys);
    ce <= 1'b0;
    tx_empty <= 1'b1;
    @(posedge clk_sys);
    tx_empty <= 1'b0;
    repeat (2) @(posedge clk_sys);
    ce <= 1'b1;
    pins();
    @(posedge clk_sys);
    tx_empty <= 1'b1;
    st |= 8'h20;
    mn = 1;
    ist |= 4;
    rreg(REG_CTRL);
    wreg(REG_CTRL, 8'h00);
    rreg(REG_STATUS);
    @(posedge clk_sys);
    tx_empty <= 1'b0;
    wreg(REG_IRQ_EN, 8'h07);
    wreg(REG_IRQ_STAT, 8'hff);
    wreg(3'h6, 8'hff);
    rreg(REG_IRQ_STAT);
    pins();
    for (int i = 0; i < 4; i++) begin
      rs = lf(rs);
      wreg(REG_IRQ_EN, rs[7:0]);
      xfer(rs[8]);
      rreg(REG_IRQ_EN);
      pins();
      wreg(REG_IRQ_CLR, rs[15:8]);
      rreg(REG_IRQ_STAT);
    end
    rreg(REG_CTRL);
    wreg(REG_CTRL, 8'h04);
    xfer(0);
    @(posedge clk_sys);
    match2 <= 1'b1;
    xfer(1);
    rreg(REG_CTRL);
    wreg(REG_CTRL, 8'h04);
    @(posedge clk_sys);
    match1 <= 1'b1;
    @(posedge clk_sys);
    match1 <= 1'b0;
    hold = 1;
    xfer(0);
    frame(9);
    xfer(0);
    rreg(REG_STATUS);
    wreg(REG_STATUS, 8'hbf);
    rreg(REG_STATUS);
    frame(4);
    rreg(REG_STATUS);
    wreg(REG_STATUS, 8'h7f);
    frame(4);
    rreg(REG_CTRL);
    wreg(REG_CTRL, 8'h06);
    rreg(REG_STATUS);
    frame(9);
    wreg(REG_CTRL, 8'h00);
    frame(4);
    rreg(REG_STATUS);
    pins();
    close_out();
  end
endmodule : isf_top_tb
